// ===== shared/encoder_cmd_pkg.sv
// constants shared by the command executor and its error pin stretcher
// assumes a single 10 MHz clock and an 8-bit register port
package encoder_cmd_pkg;

   // -------------------------------------------------------------
   // register offsets
   // -------------------------------------------------------------
   localparam logic [7:0] ADDR_MESSAGE_MASK  = 8'h0C;
   localparam logic [7:0] ADDR_ERR_DISPLAY   = 8'h0D;
   localparam logic [7:0] ADDR_REMOTE_FIRST  = 8'h5B;
   localparam logic [7:0] ADDR_RAM_FIRST     = 8'h5C;
   localparam logic [7:0] ADDR_RAM_LAST      = 8'h5D;
   localparam logic [7:0] ADDR_TARGET_ID     = 8'h5E;
   localparam logic [7:0] ADDR_SWITCH_TARGET = 8'h60;
   localparam logic [7:0] ADDR_EVENT_COUNTER = 8'h73;
   localparam logic [7:0] ADDR_COMMAND       = 8'h75;
   localparam logic [7:0] ADDR_SECOND_STATUS_REGISTER       = 8'h77;

   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int CFG_ACCUM_BIT  = 7;
   localparam int CFG_NOCRC_BIT  = 6;
   localparam int ST_CRC_BIT     = 7;
   localparam int ST_EPR_BIT     = 6;
   localparam int ST_MTERR_BIT   = 5;
   localparam int ST_TURN_BIT    = 4;
   localparam int ST_PERIOD_BIT  = 3;
   localparam int ST_FREQ_BIT    = 1;
   localparam int ST_BUSY_BIT    = 0;
   localparam int MSK_TURN_BIT   = 7;
   localparam int MSK_PERIOD_BIT = 6;
   localparam int MSK_SIGNAL_BIT = 5;
   localparam int MSK_EPR_BIT    = 4;
   localparam int MSK_CRC_BIT    = 3;
   localparam int MSK_BUSY_BIT   = 2;
   localparam int MSK_FREQ_BIT   = 1;

   // -------------------------------------------------------------
   // command codes
   // -------------------------------------------------------------
   localparam logic [7:0] CMD_WRITE_ALL         = 8'h01;
   localparam logic [7:0] CMD_WRITE_OFFSETS     = 8'h02;
   localparam logic [7:0] CMD_ABSOLUTE_REDEFINE = 8'h03;
   localparam logic [7:0] CMD_PERIOD_VERIFY     = 8'h04;
   localparam logic [7:0] CMD_TURN_COUNT_RELOAD = 8'h05;
   localparam logic [7:0] CMD_TURN_COUNT_VERIFY = 8'h06;
   localparam logic [7:0] CMD_SOFT_RESET        = 8'h07;
   localparam logic [7:0] CMD_PRESET_VOLATILE   = 8'h08;
   localparam logic [7:0] CMD_PRESET_PERSIST    = 8'h09;
   localparam logic [7:0] CMD_USER_TRANSFER     = 8'h0A;
   localparam logic [7:0] CMD_EVENT_INCREMENT   = 8'h0B;
   localparam logic [7:0] CMD_MODE_SWITCH       = 8'h0C;
   localparam logic [7:0] CMD_CHECKSUM_VERIFY   = 8'h0D;
   localparam logic [7:0] CMD_CHECKSUM_RECOMP   = 8'h0E;
   localparam logic [7:0] CMD_AUX_OUT_HIGH      = 8'h0F;
   localparam logic [7:0] CMD_AUX_OUT_LOW       = 8'h10;

   localparam logic [1:0] PROT_FULL        = 2'h0;
   localparam logic [1:0] PROT_WITH_BUS    = 2'h2;
   localparam logic [3:0] TURN_NONE        = 4'h0;
   localparam logic [1:0] MAX_RETRIES      = 2'h3;

   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int MCLK_PERIOD_NS   = 100;
   localparam int ERR_STEP_NS      = 12_500_000;
   localparam int ERR_STEP_CYCLES  = ERR_STEP_NS / MCLK_PERIOD_NS;
   localparam int HOLD_W           = 20;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN  = 3'b010,
      ST_WAIT = 3'b100
   } exec_state_t;

endpackage

// ===== src/error_pin_stretch.sv
// open-collector error pin driver with a minimum assertion time
// assumes err_active is already gated by pin selection and message mask
`timescale 1ns/100ps
module error_pin_stretch
   import encoder_cmd_pkg::*;
#(
   parameter int STEP_CYCLES = ERR_STEP_CYCLES
)(
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic       err_active,
   input  wire logic [2:0] display_time,
   output logic            pin_out,
   output logic            pin_oe_n
);

   typedef struct packed {
      logic [HOLD_W-1:0] hold;
      logic              drive;
   } stretch_t;

   stretch_t s_reg;
   stretch_t s_next;
   logic [HOLD_W-1:0] hold_load;

   // reloading while the error stands keeps the hold measured from the latest error
   assign hold_load = HOLD_W'(display_time * STEP_CYCLES);

   always_comb begin
      s_next = s_reg;
      if (err_active) begin
         s_next.drive = 1'b1;
         s_next.hold  = hold_load; // RULE2
      end else if (s_reg.hold != '0) begin
         s_next.drive = 1'b1;
         s_next.hold  = s_reg.hold - HOLD_W'(1);
      end else begin
         s_next.drive = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // the pin only ever pulls low; the line is released otherwise
   assign pin_out  = 1'b0;
   assign pin_oe_n = ~s_reg.drive; // RULE1

   chk_pin_hold: assert property (@(posedge mclk) disable iff (!nrst) // RULE2
      (!err_active && s_reg.hold != '0) |=> !pin_oe_n)
      else $error("error pin released before display time");

endmodule

// ===== src/encoder_command_executor.sv
// command register, sequencing and status flags of the position encoder
// assumes an external engine runs the long sequences via eng_start/eng_done
`timescale 1ns/100ps
// Summary of operation
// RULE1: enabled masked internal errors drive the open-collector active-low error pin.
// RULE2: each error pin assertion lasts at least display code times 12.5 ms.
// RULE3: a zero mask bit passes its message, a one suppresses it.
// RULE4: writing the command register starts a command; reserved codes do nothing.
// RULE5: write-all stores configuration, offsets and presets, updating both checksums.
// RULE6: write-offsets stores offset and preset area, updating the short checksum.
// RULE7: absolute redefine recalculates nonius, syncs turns, amends offsets, restarts converters.
// RULE8: period verify compares nonius result to counted period, flags mismatch.
// RULE9: turn reload re-syncs external turns into offsets without converter restart.
// RULE10: turn verify compares external and counted turns, flags mismatch.
// RULE11: soft reset clears machines, reloads configuration, then redefines absolute value.
// RULE12: preset commands set output to preset; persistent one also stores offsets.
// RULE13: user bus transfer only at protection 0 or 2, parameters loaded first.
// RULE14: a failed user bus transfer is retried at most three more times.
// RULE15: byte count is last RAM address minus first RAM address.
// RULE16: event command increments the event counter by exactly one.
// RULE17: mode switch needs full access, applies targets while writing, then restores.
// RULE18: after a switch, checksum error sets if checking on and targets differ.
// RULE19: target interface mode is bits 2:0 of the exchange register.
// RULE20: target protection level is bits 7:6 of the exchange register.
// RULE21: checksum verify flags mismatch; checksum recompute refreshes stored checksums.
// RULE22: aux output commands capture aux input first, only without external turns.
// RULE23: busy bit 0 of second status stays high while a command executes.
// RULE24: in accumulate mode redefine or soft reset clears accumulated status bits.
// RULE25: command writes while busy are ignored.
module encoder_command_executor
   import encoder_cmd_pkg::*;
#(
   parameter int ERR_HOLD_STEP = ERR_STEP_CYCLES
)(
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic [2:0] interface_mode_select,
   input  wire logic [1:0] protection_level,
   input  wire logic [3:0] turn_count_config,
   input  wire logic       error_pin_select,
   input  wire logic       signal_error,
   input  wire logic       freq_warning,
   input  wire logic       turn_comm_error,
   input  wire logic       eng_done,
   input  wire logic       eng_error,
   input  wire logic       eng_mismatch,
   input  wire logic       aux_input_pin,
   output logic            eng_start,
   output logic      [7:0] eng_op,
   output logic      [7:0] bus_target_id,
   output logic      [7:0] remote_first_address,
   output logic      [7:0] ram_first_address,
   output logic      [7:0] byte_count,
   output logic      [2:0] applied_mode,
   output logic      [1:0] applied_protection,
   output logic            aux_output_pin,
   output logic      [7:0] second_status_register,
   output logic            error_pin_n_out,
   output logic            error_pin_n_oe_n
);

   typedef struct packed {
      exec_state_t state;
      logic [7:0]  op;
      logic [1:0]  tries;
      logic [7:0]  mask;
      logic [2:0]  disp_time;
      logic        accum;
      logic        crc_dis;
      logic [7:0]  remote_first;
      logic [7:0]  ram_first;
      logic [7:0]  ram_last;
      logic [7:0]  target_id;
      logic [2:0]  target_mode;
      logic [1:0]  target_prot;
      logic [7:0]  events;
      logic        capture;
      logic        aux_out;
      logic        sync1;
      logic        sync2;
      logic        crc_flag;
      logic        epr_flag;
      logic        turn_flag;
      logic        period_flag;
      logic        start;
      logic [7:0]  count;
      logic [2:0]  amode;
      logic [1:0]  aprot;
      logic [7:0]  rdata;
      logic [7:0]  status;
      logic        err;
   } core_t;

   core_t c_reg;
   core_t c_next;

   logic       cmd_write;
   logic       code_valid;
   logic       code_allowed;
   logic       status_read;
   logic       accum_clear;
   logic       local_op;
   logic [7:0] err_sources;

   // -------------------------------------------------------------
   // command decode
   // -------------------------------------------------------------
   assign cmd_write   = reg_wr && (reg_addr == ADDR_COMMAND);
   assign status_read = reg_rd && (reg_addr == ADDR_SECOND_STATUS_REGISTER);

   // codes 0x00 and 0x11 and above are reserved
   assign code_valid = (reg_wdata >= CMD_WRITE_ALL) && (reg_wdata <= CMD_AUX_OUT_LOW); // RULE4

   always_comb begin
      case (reg_wdata)
         CMD_USER_TRANSFER: begin
            code_allowed = (protection_level == PROT_FULL) || (protection_level == PROT_WITH_BUS); // RULE13
         end
         CMD_MODE_SWITCH: begin
            code_allowed = (protection_level == PROT_FULL); // RULE17
         end
         CMD_AUX_OUT_HIGH, CMD_AUX_OUT_LOW: begin
            code_allowed = (turn_count_config == TURN_NONE); // RULE22
         end
         default: begin
            code_allowed = 1'b1;
         end
      endcase
   end

   // these finish inside the block; all others go to the engine
   assign local_op = (c_reg.op == CMD_EVENT_INCREMENT) || (c_reg.op == CMD_AUX_OUT_HIGH) ||
                     (c_reg.op == CMD_AUX_OUT_LOW);

   // redefine and soft reset act like a status read for accumulated bits
   assign accum_clear = c_reg.accum && (status_read || (cmd_write && c_reg.state == ST_IDLE && code_valid &&
                        (reg_wdata == CMD_ABSOLUTE_REDEFINE || reg_wdata == CMD_SOFT_RESET))); // RULE24

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      c_next       = c_reg;
      c_next.start = 1'b0;
      c_next.sync1 = aux_input_pin;
      c_next.sync2 = c_reg.sync1;

      // software writes to the plain registers
      if (reg_wr) begin
         case (reg_addr)
            ADDR_MESSAGE_MASK:  c_next.mask = reg_wdata;
            ADDR_ERR_DISPLAY: begin
               c_next.accum     = reg_wdata[CFG_ACCUM_BIT];
               c_next.crc_dis   = reg_wdata[CFG_NOCRC_BIT];
               c_next.disp_time = reg_wdata[2:0]; // RULE2
            end
            ADDR_REMOTE_FIRST:  c_next.remote_first = reg_wdata;
            ADDR_RAM_FIRST:     c_next.ram_first    = reg_wdata;
            ADDR_RAM_LAST:      c_next.ram_last     = reg_wdata;
            ADDR_TARGET_ID:     c_next.target_id    = reg_wdata;
            ADDR_SWITCH_TARGET: begin
               c_next.target_mode = reg_wdata[2:0]; // RULE19
               c_next.target_prot = reg_wdata[7:6]; // RULE20
            end
            ADDR_EVENT_COUNTER: c_next.events = reg_wdata;
            default: ;
         endcase
      end

      // accumulated flags clear first so that a same-cycle event still sets them
      if (accum_clear) begin
         c_next.crc_flag    = 1'b0;
         c_next.turn_flag   = 1'b0;
         c_next.period_flag = 1'b0;
      end

      case (c_reg.state)
         ST_IDLE: begin
            // busy writes never reach here, so they are dropped
            if (cmd_write && code_valid && code_allowed) begin // RULE4 RULE25
               c_next.op    = reg_wdata;
               c_next.tries = 2'h0;
               c_next.state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (local_op) begin
               c_next.state = ST_IDLE;
               case (c_reg.op)
                  CMD_EVENT_INCREMENT: c_next.events = c_reg.events + 8'h01; // RULE16
                  CMD_AUX_OUT_HIGH: begin
                     c_next.capture = c_reg.sync2; // RULE22
                     c_next.aux_out = 1'b1;
                  end
                  default: begin
                     c_next.capture = c_reg.sync2; // RULE22
                     c_next.aux_out = 1'b0;
                  end
               endcase
            end else begin
               // RULE5 RULE6 RULE7 RULE9 RULE11 RULE12 RULE21
               c_next.start = 1'b1;
               c_next.state = ST_WAIT;
               c_next.count = c_reg.ram_last - c_reg.ram_first; // RULE15
            end
         end
         ST_WAIT: begin
            if (eng_done) begin
               if (eng_error && c_reg.op == CMD_USER_TRANSFER && c_reg.tries != MAX_RETRIES) begin
                  c_next.tries = c_reg.tries + 2'h1; // RULE14
                  c_next.state = ST_RUN;
               end else begin
                  c_next.state = ST_IDLE;
                  c_next.epr_flag = eng_error;
                  case (c_reg.op)
                     CMD_PERIOD_VERIFY: begin
                        c_next.period_flag = eng_mismatch || (c_reg.accum && c_next.period_flag); // RULE8
                     end
                     CMD_TURN_COUNT_VERIFY: begin
                        c_next.turn_flag = eng_mismatch || (c_reg.accum && c_next.turn_flag); // RULE10
                     end
                     CMD_CHECKSUM_VERIFY: begin
                        c_next.crc_flag = eng_mismatch || (c_reg.accum && c_next.crc_flag); // RULE21
                     end
                     CMD_MODE_SWITCH: begin
                        if (!c_reg.crc_dis && (c_reg.target_mode != interface_mode_select ||
                            c_reg.target_prot != protection_level)) begin
                           c_next.crc_flag = 1'b1; // RULE18
                        end
                     end
                     default: ;
                  endcase
               end
            end
         end
         default: begin
            c_next.state = ST_IDLE;
         end
      endcase

      // targets stand only while the switch writes the eeprom
      if (c_next.state == ST_WAIT && c_reg.op == CMD_MODE_SWITCH) begin
         c_next.amode = c_reg.target_mode; // RULE17
         c_next.aprot = c_reg.target_prot;
      end else begin
         c_next.amode = interface_mode_select;
         c_next.aprot = protection_level;
      end

      c_next.status = '0;
      c_next.status[ST_CRC_BIT]    = c_next.crc_flag;
      c_next.status[ST_EPR_BIT]    = c_next.epr_flag;
      c_next.status[ST_MTERR_BIT]  = turn_comm_error;
      c_next.status[ST_TURN_BIT]   = c_next.turn_flag;
      c_next.status[ST_PERIOD_BIT] = c_next.period_flag;
      c_next.status[ST_FREQ_BIT]   = freq_warning;
      c_next.status[ST_BUSY_BIT]   = (c_next.state != ST_IDLE); // RULE23

      c_next.err = error_pin_select && ((err_sources & ~c_reg.mask) != '0); // RULE1 RULE3

      // read data, one cycle after the strobe
      c_next.rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_MESSAGE_MASK:  c_next.rdata = c_reg.mask;
            ADDR_ERR_DISPLAY: begin
               c_next.rdata[CFG_ACCUM_BIT] = c_reg.accum;
               c_next.rdata[CFG_NOCRC_BIT] = c_reg.crc_dis;
               c_next.rdata[2:0]           = c_reg.disp_time;
            end
            ADDR_REMOTE_FIRST:  c_next.rdata = c_reg.remote_first;
            ADDR_RAM_FIRST:     c_next.rdata = c_reg.ram_first;
            ADDR_RAM_LAST:      c_next.rdata = c_reg.ram_last;
            ADDR_TARGET_ID:     c_next.rdata = c_reg.target_id;
            ADDR_SWITCH_TARGET: c_next.rdata = {c_reg.target_prot, 3'h0, c_reg.target_mode[2:1], c_reg.capture};
            ADDR_EVENT_COUNTER: c_next.rdata = c_reg.events;
            ADDR_SECOND_STATUS_REGISTER:       c_next.rdata = c_reg.status;
            default:            c_next.rdata = '0;
         endcase
      end
   end

   // message sources in mask bit order
   always_comb begin
      err_sources = '0;
      err_sources[MSK_TURN_BIT]   = c_reg.turn_flag || turn_comm_error;
      err_sources[MSK_PERIOD_BIT] = c_reg.period_flag;
      err_sources[MSK_SIGNAL_BIT] = signal_error;
      err_sources[MSK_EPR_BIT]    = c_reg.epr_flag;
      err_sources[MSK_CRC_BIT]    = c_reg.crc_flag;
      err_sources[MSK_BUSY_BIT]   = c_reg.state != ST_IDLE;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         c_reg       <= '0;
         c_reg.state <= ST_IDLE;
      end else begin
         c_reg <= c_next;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign reg_rdata              = c_reg.rdata;
   assign eng_start              = c_reg.start;
   assign eng_op                 = c_reg.op;
   assign bus_target_id          = c_reg.target_id;
   assign remote_first_address   = c_reg.remote_first;
   assign ram_first_address      = c_reg.ram_first;
   assign byte_count             = c_reg.count;
   assign applied_mode           = c_reg.amode;
   assign applied_protection     = c_reg.aprot;
   assign aux_output_pin         = c_reg.aux_out;
   assign second_status_register = c_reg.status;

   error_pin_stretch #(
      .STEP_CYCLES (ERR_HOLD_STEP)
   ) u_err_pin (
      .mclk         (mclk),
      .nrst         (nrst),
      .err_active   (c_reg.err),
      .display_time (c_reg.disp_time),
      .pin_out      (error_pin_n_out),
      .pin_oe_n     (error_pin_n_oe_n)
   );

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   chk_busy_bit: assert property (@(posedge mclk) disable iff (!nrst) // RULE23
      (c_reg.state == ST_WAIT && eng_done && c_reg.op != CMD_USER_TRANSFER)
      |=> !second_status_register[ST_BUSY_BIT])
      else $error("busy bit disagrees with execution state");

   chk_reserved_code: assert property (@(posedge mclk) disable iff (!nrst) // RULE4
      (c_reg.state == ST_IDLE && cmd_write && !code_valid) |=> c_reg.state == ST_IDLE)
      else $error("reserved code started a command");

   chk_event_step: assert property (@(posedge mclk) disable iff (!nrst) // RULE16
      (c_reg.state == ST_IDLE && cmd_write && reg_wdata == CMD_EVENT_INCREMENT)
      |-> ##2 c_reg.events == $past(c_reg.events, 2) + 8'h01)
      else $error("event counter did not step by one");

   chk_busy_ignore: assert property (@(posedge mclk) disable iff (!nrst) // RULE25
      (c_reg.state != ST_IDLE && cmd_write) |=> $stable(c_reg.op))
      else $error("command accepted while busy");

   chk_retry_limit: assert property (@(posedge mclk) disable iff (!nrst) // RULE14
      (c_reg.state == ST_WAIT && eng_done && eng_error && c_reg.tries == MAX_RETRIES)
      |=> c_reg.state == ST_IDLE)
      else $error("too many transfer attempts");

   chk_aux_capture: assert property (@(posedge mclk) disable iff (!nrst) // RULE22
      (c_reg.state == ST_RUN && (c_reg.op == CMD_AUX_OUT_HIGH || c_reg.op == CMD_AUX_OUT_LOW))
      |=> c_reg.capture == $past(c_reg.sync2) && aux_output_pin == ($past(c_reg.op) == CMD_AUX_OUT_HIGH))
      else $error("aux pin command wrong");

   chk_bus_guard: assert property (@(posedge mclk) disable iff (!nrst) // RULE13
      (c_reg.state == ST_IDLE && cmd_write && reg_wdata == CMD_USER_TRANSFER && protection_level[0])
      |=> c_reg.state == ST_IDLE)
      else $error("transfer started at forbidden protection");

   chk_switch_restore: assert property (@(posedge mclk) disable iff (!nrst) // RULE17
      (c_reg.state == ST_IDLE && $past(c_reg.state) == ST_IDLE) |-> applied_mode == $past(interface_mode_select))
      else $error("applied mode not restored");

   chk_byte_count: assert property (@(posedge mclk) disable iff (!nrst) // RULE15
      $rose(eng_start) |-> byte_count == $past(c_reg.ram_last - c_reg.ram_first))
      else $error("byte count wrong");

endmodule

// ===== verif/eng_model.sv
// sequence engine partner: answers each eng_start after dly cycles
// assumes the bench sets fail and mis before the command is written
`timescale 1ns/100ps
module eng_model(
   input  wire logic       mclk,
   input  wire logic       eng_start,
   input  wire logic [7:0] dly,
   input  wire logic       fail,
   input  wire logic       mis,
   output logic            eng_done = 1'b0,
   output logic            eng_error = 1'b0,
   output logic            eng_mismatch = 1'b0
);
   int cnt = 0;
   // result lines toggle outside the done pulse so a stale value is never trusted
   always @(posedge mclk) begin
      eng_done <= 1'b0;
      eng_error <= ~eng_error;
      eng_mismatch <= ~eng_mismatch;
      if (eng_start) begin
         cnt <= dly;
      end else if (cnt == 1) begin
         cnt <= 0;
         eng_done <= 1'b1;
         eng_error <= fail;
         eng_mismatch <= mis;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule

// ===== verif/encoder_command_executor_test.sv
// bench for the command executor: row table of codes, then hand tests
// assumes eng_model stands in for the sequence engine
`timescale 1ns/100ps
module encoder_command_executor_test;
   logic       mclk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, error_pin_select = 0, signal_error = 0, seen;
   logic       freq_warning = 0, turn_comm_error = 0, aux_input_pin = 0, fail = 0, mis = 0;
   logic       eng_done, eng_error, eng_mismatch, eng_start, aux_output_pin, error_pin_n_out, error_pin_n_oe_n;
   logic [7:0] reg_addr = 0, reg_wdata = 0, dly = 8'h05, reg_rdata, eng_op, bus_target_id, rv, op;
   logic [7:0] remote_first_address, ram_first_address, byte_count, second_status_register;
   logic [2:0] interface_mode_select = 0, applied_mode;
   logic [1:0] protection_level = 0, applied_protection;
   logic [4:0] am;
   logic [3:0] turn_count_config = 0;
   int         failures = 0, n_checks = 0, starts;
   // {busy expected, engine start expected, code}
   logic [9:0] rows [19] = '{10'h000, 10'h301, 10'h302, 10'h303, 10'h304, 10'h305, 10'h306, 10'h307, 10'h308,
      10'h309, 10'h30A, 10'h20B, 10'h30C, 10'h30D, 10'h30E, 10'h20F, 10'h210, 10'h011, 10'h0FF};

   encoder_command_executor #(.ERR_HOLD_STEP(10)) i_dut (.*);
   eng_model i_eng (.*);

   initial forever #50 mclk = ~mclk;
   always @(posedge mclk) begin
      if (eng_start) starts <= starts + 1;
      if (eng_start) {am, op} <= {applied_protection, applied_mode, eng_op};
      if (second_status_register[0]) seen <= 1'b1;
   end

   task automatic chk(string n, logic [7:0] e, logic [7:0] s);
      n_checks++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(negedge mclk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(negedge mclk) reg_wr = 0;
   endtask
   task automatic rd(logic [7:0] a);
      @(negedge mclk) {reg_addr, reg_rd} = {a, 1'b1};
      @(negedge mclk) reg_rd = 0;
      rv = reg_rdata;
   endtask
   task automatic cmd(logic [7:0] c);
      {starts, seen, op} = 0;
      wr(8'h75, c);
      repeat (2) @(negedge mclk);
      for (int i = 0; i < 200 && second_status_register[0] !== 1'b0; i++) @(negedge mclk);
      chk("idle", 8'h00, {7'h0, second_status_register[0]});
   endtask
   task automatic complete_run;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (10) @(negedge mclk);
      nrst = 1;
      chk("status", 8'h00, second_status_register);
      chk("pin oe", 8'h01, {7'h0, error_pin_n_oe_n});
      foreach (rows[i]) begin
         cmd(rows[i][7:0]);
         chk("starts", {7'h0, rows[i][8]}, starts[7:0]);
         chk("busy", {7'h0, rows[i][9]}, {7'h0, seen});
         chk("op", rows[i][8] ? rows[i][7:0] : 8'h00, op);
      end
      rd(8'h70);
      chk("unmapped", 8'h00, rv);
      wr(8'h73, 8'hFF);
      cmd(8'h0B);
      rd(8'h73);
      chk("events", 8'h00, rv);
      {dly, mis} = {8'h40, 1'b1};
      wr(8'h75, 8'h04);
      cmd(8'h0B);
      rd(8'h73);
      chk("events busy", 8'h00, rv);
      chk("period flag", 8'h08, second_status_register & 8'h08);
      dly = 8'h05;
      cmd(8'h06);
      chk("turn flag", 8'h10, second_status_register & 8'h10);
      {mis, fail} = 2'b01;
      cmd(8'h0A);
      chk("retries", 8'h04, starts[7:0]);
      chk("eeprom flag", 8'h40, second_status_register & 8'h40);
      fail = 0;
      wr(8'h5B, 8'h33);
      wr(8'h5C, 8'h10);
      wr(8'h5D, 8'h25);
      wr(8'h5E, 8'hA1);
      cmd(8'h0A);
      chk("byte count", 8'h15, byte_count);
      chk("target id", 8'hA1, bus_target_id);
      chk("remote first", 8'h33, remote_first_address);
      chk("ram first", 8'h10, ram_first_address);
      protection_level = 2'h1;
      cmd(8'h0A);
      chk("prot bus", 8'h00, starts[7:0]);
      cmd(8'h0C);
      chk("prot switch", 8'h00, starts[7:0]);
      {protection_level, aux_input_pin} = 3'b001;
      cmd(8'h0F);
      rd(8'h60);
      chk("aux out", 8'h01, {7'h0, aux_output_pin});
      chk("aux capture", 8'h01, rv & 8'h01);
      turn_count_config = 4'h1;
      cmd(8'h10);
      chk("aux kept", 8'h01, {7'h0, aux_output_pin});
      wr(8'h0C, 8'hE0);
      wr(8'h0D, 8'h02);
      {error_pin_select, signal_error} = 2'b11;
      repeat (5) @(negedge mclk);
      chk("masked pin", 8'h01, {7'h0, error_pin_n_oe_n});
      wr(8'h0C, 8'hC0);
      repeat (3) @(negedge mclk);
      chk("pin on", 8'h00, {7'h0, error_pin_n_oe_n});
      chk("pin level", 8'h00, {7'h0, error_pin_n_out});
      signal_error = 0;
      repeat (15) @(negedge mclk);
      chk("pin held", 8'h00, {7'h0, error_pin_n_oe_n});
      repeat (15) @(negedge mclk);
      chk("pin off", 8'h01, {7'h0, error_pin_n_oe_n});
      wr(8'h60, 8'h43);
      cmd(8'h0C);
      chk("switch applied", 8'h0B, {3'h0, am});
      chk("restored", 8'h00, {3'h0, applied_protection, applied_mode});
      chk("switch crc", 8'h80, second_status_register & 8'h80);
      rd(8'h60);
      chk("exchange", 8'h43, rv);
      wr(8'h0D, 8'h80);
      cmd(8'h03);
      chk("accum clear", 8'h00, second_status_register & 8'h98);
      mis = 1;
      cmd(8'h0D);
      chk("crc verify", 8'h80, second_status_register & 8'h80);
      rd(8'h77);
      chk("status read", 8'h80, rv & 8'h80);
      chk("read clear", 8'h00, second_status_register & 8'h80);
      complete_run();
   end
   // span is ample for about 400 cycles of tests
   initial begin
      #2_000_000;
      failures++;
      complete_run();
   end
endmodule
